//--- verilog/lmcs_defines.vh
// constants for the logger mission control and status block
`ifndef LMCS_DEFINES_VH
`define LMCS_DEFINES_VH
`define LMCS_ADDR_CFG 10'h213
`define LMCS_ADDR_ALM 10'h214
`define LMCS_ADDR_STS 10'h215
`define LMCS_CFG_TLOG 0
`define LMCS_CFG_HLOG 1
`define LMCS_CFG_TWIDE 2
`define LMCS_CFG_HWIDE 3
`define LMCS_CFG_ROLL 4
`define LMCS_CFG_START_ON_TEMP_ALARM 5
`define LMCS_CFG_RESET 6'h00
`define LMCS_CFG_FIXED 2'h3
`define LMCS_ALM_FIXED 3'h7
`define LMCS_LOG_BASE 13'h1000
`define LMCS_LOG_END 14'h3000
`define LMCS_HUM_EQ 14'h2000
`define LMCS_HUM_T8H16 14'h1A00
`define LMCS_HUM_T16H8 14'h2400
`define LMCS_PTR_W 14
`endif

//--- verilog/lmcs_top.v
// mission configuration, alarm flags and status logic of the data logger
`timescale 1ns/10ps
`include "lmcs_defines.vh"
module lmcs_top (
  input wire mclk_i,
  input wire rst_n_i,
  input wire reg_wr_i,
  input wire [9:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire clear_memory_i,
  input wire start_mission_i,
  input wire stop_mission_i,
  input wire forced_conv_i,
  input wire sample_tick_i,
  input wire temp_high_alarm_enable_i,
  input wire temp_low_alarm_enable_i,
  input wire humid_high_alarm_enable_i,
  input wire humid_low_alarm_enable_i,
  input wire [7:0] temp_high_thr_i,
  input wire [7:0] temp_low_thr_i,
  input wire [7:0] humid_high_thr_i,
  input wire [7:0] humid_low_thr_i,
  input wire [15:0] temp_sample_i,
  input wire [15:0] humid_sample_i,
  output reg [7:0] reg_rdata_o,
  output reg log_wr_o,
  output reg [13:0] log_addr_o,
  output reg [7:0] log_data_o,
  output reg temp_conv_8bit_o,
  output reg conv_run_o,
  output reg start_ok_o,
  output reg [13:0] temp_start_o,
  output reg [13:0] humid_start_o
);
////////////////////////////////////////////////////////////////////////
reg [5:0] cfg_r;
reg battery_reset_flag_r, humid_high_flag_r, humid_low_flag_r, temp_high_flag_r, temp_low_flag_r;
reg awaiting_temp_alarm_r, memory_cleared_flag_r, mission_active_r, log_full_r;
reg [13:0] tptr_r, hptr_r;
reg [2:0] wq_cnt_r;
reg [7:0] wq_b0_r, wq_b1_r, wq_b2_r, wq_b3_r;
reg [13:0] wq_a0_r, wq_a1_r;
reg [2:0] wq_kind_r;
reg [7:0] rdata_nxt;
wire temp_log_enable = cfg_r[`LMCS_CFG_TLOG];
wire humid_log_enable = cfg_r[`LMCS_CFG_HLOG];
wire temp_format_wide = cfg_r[`LMCS_CFG_TWIDE];
wire humid_format_wide = cfg_r[`LMCS_CFG_HWIDE];
wire rollover_enable = cfg_r[`LMCS_CFG_ROLL];
wire start_on_temp_alarm = cfg_r[`LMCS_CFG_START_ON_TEMP_ALARM];
////////////////////////////////////////////////////////////////////////
// start address decode
function [13:0] hum_start;
  input tl, tw, hw;
  begin
    if (!tl)
      hum_start = {1'b0, `LMCS_LOG_BASE};
    else if (tw == hw)
      hum_start = `LMCS_HUM_EQ;
    else if (hw)
      hum_start = `LMCS_HUM_T8H16;
    else
      hum_start = `LMCS_HUM_T16H8;
  end
endfunction
// pointer advance with wrap or full
function [14:0] ptr_adv;
  input [13:0] p;
  input [13:0] base;
  input [13:0] lim;
  input wide;
  reg [14:0] n;
  begin
    n = {1'b0, p} + (wide ? 15'h0002 : 15'h0001);
    if (n[13:0] >= lim || n[14])
      ptr_adv = {1'b1, base};
    else
      ptr_adv = n;
  end
endfunction
wire [13:0] t_base = {1'b0, `LMCS_LOG_BASE};
wire [13:0] h_base = hum_start(temp_log_enable, temp_format_wide, humid_format_wide);
wire [13:0] t_lim = humid_log_enable ? h_base : `LMCS_LOG_END;
wire [13:0] h_lim = `LMCS_LOG_END;
////////////////////////////////////////////////////////////////////////
// alarm evaluation, high byte of each sample
wire [7:0] t_val = temp_sample_i[15:8];
wire [7:0] h_val = humid_sample_i[15:8];
wire in_mis = mission_active_r && sample_tick_i && !log_full_r;
wire conv_ev = in_mis || (forced_conv_i && !mission_active_r);
wire t_hi = conv_ev && (temp_log_enable || forced_conv_i) && temp_high_alarm_enable_i && (t_val >= temp_high_thr_i);
wire t_lo = conv_ev && (temp_log_enable || forced_conv_i) && temp_low_alarm_enable_i && (t_val <= temp_low_thr_i);
wire h_hi = conv_ev && (humid_log_enable || forced_conv_i) && humid_high_alarm_enable_i && (h_val >= humid_high_thr_i);
wire h_lo = conv_ev && (humid_log_enable || forced_conv_i) && humid_low_alarm_enable_i && (h_val <= humid_low_thr_i);
wire t_alarm = t_hi || t_lo;
wire can_start = memory_cleared_flag_r && (temp_log_enable || humid_log_enable) && !mission_active_r;
wire do_start = start_mission_i && can_start;
wire logging = in_mis && !(awaiting_temp_alarm_r && !t_alarm);
wire t_do = logging && temp_log_enable;
wire h_do = logging && humid_log_enable;
wire [14:0] t_adv = ptr_adv(tptr_r, t_base, t_lim, temp_format_wide);
wire [14:0] h_adv = ptr_adv(hptr_r, h_base, h_lim, humid_format_wide);
wire wrap = (t_do && t_adv[14]) || (h_do && h_adv[14]);
////////////////////////////////////////////////////////////////////////
// configuration register
always @(posedge mclk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    cfg_r <= `LMCS_CFG_RESET;
  end else if (reg_wr_i && reg_addr_i == `LMCS_ADDR_CFG && !mission_active_r) begin
    cfg_r <= reg_wdata_i[5:0];
  end
end
////////////////////////////////////////////////////////////////////////
// flags and mission state
always @(posedge mclk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    battery_reset_flag_r <= 1'b1;
    humid_high_flag_r <= 1'b0;
    humid_low_flag_r <= 1'b0;
    temp_high_flag_r <= 1'b0;
    temp_low_flag_r <= 1'b0;
    awaiting_temp_alarm_r <= 1'b0;
    memory_cleared_flag_r <= 1'b0;
    mission_active_r <= 1'b0;
    log_full_r <= 1'b0;
    tptr_r <= 14'h0000;
    hptr_r <= 14'h0000;
  end else begin
    if (clear_memory_i) begin
      battery_reset_flag_r <= 1'b0;
      memory_cleared_flag_r <= 1'b1;
    end
    // set wins over clear
    humid_high_flag_r <= (humid_high_flag_r && !clear_memory_i) || h_hi;
    humid_low_flag_r <= (humid_low_flag_r && !clear_memory_i) || h_lo;
    temp_high_flag_r <= (temp_high_flag_r && !clear_memory_i) || t_hi;
    temp_low_flag_r <= (temp_low_flag_r && !clear_memory_i) || t_lo;
    if (do_start) begin
      mission_active_r <= 1'b1;
      memory_cleared_flag_r <= 1'b0;
      awaiting_temp_alarm_r <= start_on_temp_alarm && temp_log_enable;
      log_full_r <= 1'b0;
      tptr_r <= t_base;
      hptr_r <= h_base;
    end else begin
      if (t_alarm)
        awaiting_temp_alarm_r <= 1'b0;
      if (stop_mission_i)
        mission_active_r <= 1'b0;
      if (t_do)
        tptr_r <= t_adv[13:0];
      if (h_do)
        hptr_r <= h_adv[13:0];
      if (wrap && !rollover_enable)
        log_full_r <= 1'b1;
    end
  end
end
////////////////////////////////////////////////////////////////////////
// log write sequencer, one byte per cycle, high byte first
always @(posedge mclk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    wq_cnt_r <= 3'h0;
    wq_kind_r <= 3'h0;
    wq_b0_r <= 8'h00;
    wq_b1_r <= 8'h00;
    wq_b2_r <= 8'h00;
    wq_b3_r <= 8'h00;
    wq_a0_r <= 14'h0000;
    wq_a1_r <= 14'h0000;
    log_wr_o <= 1'b0;
    log_addr_o <= 14'h0000;
    log_data_o <= 8'h00;
  end else if (t_do || h_do) begin
    wq_b0_r <= temp_format_wide ? temp_sample_i[15:8] : t_val;
    wq_b1_r <= temp_sample_i[7:0];
    wq_b2_r <= humid_format_wide ? humid_sample_i[15:8] : h_val;
    wq_b3_r <= humid_sample_i[7:0];
    wq_a0_r <= tptr_r;
    wq_a1_r <= hptr_r;
    wq_kind_r <= {h_do, t_do, 1'b0};
    wq_cnt_r <= 3'h4;
    log_wr_o <= 1'b0;
  end else if (wq_cnt_r != 3'h0) begin
    wq_cnt_r <= wq_cnt_r - 3'h1;
    case (wq_cnt_r)
      3'h4: begin
        log_wr_o <= wq_kind_r[1];
        log_addr_o <= wq_a0_r;
        log_data_o <= wq_b0_r;
      end
      3'h3: begin
        log_wr_o <= wq_kind_r[1] && temp_format_wide;
        log_addr_o <= wq_a0_r + 14'h0001;
        log_data_o <= wq_b1_r;
      end
      3'h2: begin
        log_wr_o <= wq_kind_r[2];
        log_addr_o <= wq_a1_r;
        log_data_o <= wq_b2_r;
      end
      3'h1: begin
        log_wr_o <= wq_kind_r[2] && humid_format_wide;
        log_addr_o <= wq_a1_r + 14'h0001;
        log_data_o <= wq_b3_r;
      end
      default: begin
        log_wr_o <= 1'b0;
      end
    endcase
  end else begin
    log_wr_o <= 1'b0;
  end
end
////////////////////////////////////////////////////////////////////////
// read mux and status outputs
always @* begin
  case (reg_addr_i)
    `LMCS_ADDR_CFG: rdata_nxt = {`LMCS_CFG_FIXED, cfg_r};
    `LMCS_ADDR_ALM: rdata_nxt = {battery_reset_flag_r, `LMCS_ALM_FIXED, humid_high_flag_r, humid_low_flag_r,
                                 temp_high_flag_r, temp_low_flag_r};
    `LMCS_ADDR_STS: rdata_nxt = {2'h3, 1'b0, awaiting_temp_alarm_r, memory_cleared_flag_r, 1'b0,
                                 mission_active_r, 1'b0};
    default: rdata_nxt = 8'h00;
  endcase
end
always @(posedge mclk_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    reg_rdata_o <= 8'h00;
    temp_conv_8bit_o <= 1'b0;
    conv_run_o <= 1'b0;
    start_ok_o <= 1'b0;
    temp_start_o <= 14'h0000;
    humid_start_o <= 14'h0000;
  end else begin
    reg_rdata_o <= rdata_nxt;
    temp_conv_8bit_o <= awaiting_temp_alarm_r && mission_active_r;
    conv_run_o <= mission_active_r && !log_full_r;
    start_ok_o <= do_start;
    temp_start_o <= t_base;
    humid_start_o <= h_base;
  end
end
endmodule // lmcs_top

//--- test/lmcs_monitor.sv
// assertion checker for the mission control block
`timescale 1ns/10ps
module lmcs_monitor (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [9:0] reg_addr_i,
  input wire start_mission_i,
  input wire stop_mission_i,
  input wire [7:0] reg_rdata_o,
  input wire log_wr_o,
  input wire [13:0] log_addr_o,
  input wire conv_run_o,
  input wire start_ok_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_idle; !conv_run_o [*6]; endsequence
  ////////////////
  chk_start_ack: assert property (start_ok_o |-> $past(start_mission_i)) else $error("start ack unasked");
  chk_start_run: assert property (start_ok_o |-> ##[0:1] conv_run_o) else $error("no run");
  chk_stop_run: assert property (stop_mission_i |=> ##1 !conv_run_o) else $error("run after stop");
  chk_idle_quiet: assert property (s_idle |-> !log_wr_o) else $error("log while idle");
  chk_log_range: assert property (log_wr_o |-> log_addr_o >= 14'h1000 && log_addr_o < 14'h3000)
    else $error("log address");
  chk_cfg_fixed: assert property (reg_addr_i == 10'h213 |=> reg_rdata_o[7:6] == 2'h3) else $error("cfg bits");
  chk_alarm_fixed: assert property (reg_addr_i == 10'h214 |=> reg_rdata_o[6:4] == 3'h7)
    else $error("alarm bits");
  chk_status_fixed: assert property (reg_addr_i == 10'h215 |=> (reg_rdata_o & 8'hE5) == 8'hC0)
    else $error("status bits");
endmodule // lmcs_monitor
bind lmcs_top lmcs_monitor u_mon (.mclk_i, .rst_n_i, .reg_addr_i, .start_mission_i, .stop_mission_i,
  .reg_rdata_o, .log_wr_o, .log_addr_o, .conv_run_o, .start_ok_o);

//--- test/lmcs_host_model.sv
// host model: register access and command pulses
`timescale 1ns/10ps
module lmcs_host_model (
  input wire mclk_i,
  input wire [7:0] reg_rdata_i,
  input wire start_ok_i,
  output reg reg_wr_o = 1'h0,
  output reg [9:0] reg_addr_o = 10'h000,
  output reg [7:0] reg_wdata_o = 8'h00,
  output reg [3:0] cmd_o = 4'h0
);
  task wr(input [9:0] a, input [7:0] d);
    @(posedge mclk_i) {reg_addr_o, reg_wdata_o, reg_wr_o} <= {a, d, 1'h1};
    @(posedge mclk_i) {reg_wr_o, reg_wdata_o} <= {1'h0, ~d};
  endtask
  task rd(input [9:0] a, output [7:0] d);
    @(posedge mclk_i) reg_addr_o <= a;
    repeat (2) @(posedge mclk_i);
    #1 d = reg_rdata_i;
  endtask
  // ok is the start ack; a start needs cleared memory and logging enabled
  task cmd(input [3:0] c, output ok);
    @(posedge mclk_i) cmd_o <= c;
    @(posedge mclk_i) cmd_o <= 4'h0;
    #1 ok = start_ok_i;
  endtask
endmodule // lmcs_host_model

//--- test/tb_top.sv
// self-checking bench for the mission control block
`timescale 1ns/10ps
module tb_top;
  localparam [39:0] CFGS = {8'h03, 8'h07, 8'h0B, 8'h0F, 8'h02};
  localparam [69:0] HUMS = {14'h2000, 14'h2400, 14'h1A00, 14'h2000, 14'h1000};
  reg mclk_i = 1'h0, rst_n_i = 1'h0, sample_tick_i = 1'h0, ok;
  reg [3:0] alarm_en = 4'hE;
  reg [15:0] ts = 16'hA1B2;
  reg [7:0] d;
  reg [21:0] logq [$];
  integer i, mismatches = 0, comparisons = 0;
  wire reg_wr_i, log_wr_o, temp_conv_8bit_o, conv_run_o, start_ok_o;
  wire [3:0] cmd;
  wire [7:0] reg_wdata_i, reg_rdata_o, log_data_o;
  wire [9:0] reg_addr_i;
  wire [13:0] log_addr_o, temp_start_o, humid_start_o;
  ////////////////
  lmcs_top DUT (.mclk_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .sample_tick_i,
    .clear_memory_i(cmd[0]), .start_mission_i(cmd[1]), .stop_mission_i(cmd[2]), .forced_conv_i(cmd[3]),
    .temp_high_alarm_enable_i(alarm_en[3]), .temp_low_alarm_enable_i(alarm_en[2]),
    .humid_high_alarm_enable_i(alarm_en[1]), .humid_low_alarm_enable_i(alarm_en[0]), .temp_sample_i(ts),
    .temp_high_thr_i(8'hA0), .temp_low_thr_i(8'h00), .humid_high_thr_i(8'hC0), .humid_low_thr_i(8'hC3),
    .humid_sample_i(16'hC3D4), .reg_rdata_o, .log_wr_o, .log_addr_o, .log_data_o, .temp_conv_8bit_o,
    .conv_run_o, .start_ok_o, .temp_start_o, .humid_start_o);
  lmcs_host_model u_host (.mclk_i, .reg_rdata_i(reg_rdata_o), .start_ok_i(start_ok_o), .reg_wr_o(reg_wr_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .cmd_o(cmd));
  initial forever #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (log_wr_o) logq.push_back({log_addr_o, log_data_o});
  task chk(input [63:0] got, input [63:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task rc(input [9:0] a, input [7:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask
  task tick;
    @(posedge mclk_i) sample_tick_i <= 1'h1;
    @(posedge mclk_i) sample_tick_i <= 1'h0;
    repeat (8) @(posedge mclk_i);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    rc(10'h214, 8'hF0);
    u_host.cmd(4'h1, ok);
    rc(10'h214, 8'h70);
    rc(10'h215, 8'hC8);
    u_host.cmd(4'h2, ok);
    chk(ok, 1'h0);
    for (i = 0; i < 5; i = i + 1) begin
      u_host.wr(10'h213, CFGS[i*8 +: 8]);
      @(posedge mclk_i);
      #1;
      chk(humid_start_o, HUMS[i*14 +: 14]);
      if (CFGS[i*8])
        chk(temp_start_o, 14'h1000);
    end
    $display("test clear and layout done");
    u_host.wr(10'h213, 8'h0F);
    u_host.cmd(4'h2, ok);
    rc(10'h215, 8'hC2);
    u_host.wr(10'h213, 8'h00);
    rc(10'h213, 8'hCF);
    tick;
    chk({logq[0][7:0], logq[1][7:0], logq[2][7:0], logq[3][7:0]}, 32'hA1B2C3D4);
    chk({logq[0][21:8], logq[1][21:8], logq[2][21:8], logq[3][21:8]}, 56'h40010018002001);
    rc(10'h214, 8'h7A);
    u_host.cmd(4'h4, ok);
    u_host.cmd(4'h2, ok);
    chk(ok, 1'h0);
    $display("test mission done");
    u_host.cmd(4'h1, ok);
    u_host.wr(10'h213, 8'h21);
    alarm_en <= 4'hF;
    u_host.cmd(4'h2, ok);
    rc(10'h215, 8'hD2);
    chk(temp_conv_8bit_o, 1'h1);
    ts <= 16'h5566;
    tick;
    ts <= 16'hA1B2;
    tick;
    chk(logq[4], {14'h1000, 8'hA1});
    rc(10'h215, 8'hC2);
    $display("test alarm start done");
    u_host.cmd(4'h4, ok);
    u_host.cmd(4'h1, ok);
    u_host.cmd(4'h2, ok);
    u_host.cmd(4'h4, ok);
    rc(10'h215, 8'hD0);
    u_host.cmd(4'h8, ok);
    rc(10'h215, 8'hC0);
    rc(10'h214, 8'h7E);
    $display("test stale wait clear done");
    summarize;
  end
endmodule // tb_top
